/* rtl/ocl_limit_regs.v */
// paged overcurrent limit register bank with fault, warning and retry control
`timescale 1ns/1ps
`default_nettype none
`include "ocl_regs.vh"
module ocl_limit_regs (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire        page_in,
  input  wire        cmd_wr_in,
  input  wire [7:0]  cmd_code_in,
  input  wire [15:0] cmd_data_in,
  output reg  [15:0] rd_data_out,
  input  wire [6:0]  iout0_mant_in,
  input  wire [6:0]  iout1_mant_in,
  input  wire [1:0]  uv_fault_in,
  input  wire [1:0]  enable_cmd_in,
  input  wire        bias_ok_in,
  input  wire [1:0]  other_fault_in,
  input  wire        clear_faults_in,
  output reg  [1:0]  output_enable_out,
  output reg  [1:0]  soft_start_out,
  output reg         nvm_store_out,
  output reg  [47:0] nvm_image_out,
  output reg         command_fault_flag_out,
  output reg         invalid_data_flag_out,
  output reg  [1:0]  overcurrent_summary_flag_out,
  output reg  [1:0]  other_condition_flag_out,
  output reg  [1:0]  current_power_flag_out,
  output reg  [1:0]  overcurrent_fault_flag_out,
  output reg  [1:0]  overcurrent_warning_flag_out,
  output wire        smbalert_n_out
);
  // ----------------------------------------------------------------------
  // pin synchronisers for current, analog fault, enable and bias inputs
  // ----------------------------------------------------------------------
  reg [6:0] i0_s1, i0_s2, i0_s3, i0_q;
  reg [6:0] i1_s1, i1_s2, i1_s3, i1_q;
  reg [1:0] uv_s1, uv_s2, oth_s1, oth_s2, en_s1, en_s2;
  reg       bias_s1, bias_s2;
  always @(posedge clk_in) begin
    i0_s1   <= iout0_mant_in;
    i0_s2   <= i0_s1;
    i1_s1   <= iout1_mant_in;
    i1_s2   <= i1_s1;
    uv_s1   <= uv_fault_in;
    uv_s2   <= uv_s1;
    oth_s1  <= other_fault_in;
    oth_s2  <= oth_s1;
    en_s1   <= enable_cmd_in;
    en_s2   <= en_s1;
    bias_s1 <= bias_ok_in;
    bias_s2 <= bias_s1;
  end
  // a current word is taken only once two synced samples agree, so a skewed word never passes
  always @(posedge clk_in) begin
    i0_s3 <= i0_s2;
    i1_s3 <= i1_s2;
    if (i0_s2 == i0_s3)
      i0_q <= i0_s2;
    if (i1_s2 == i1_s3)
      i1_q <= i1_s2;
  end
  // ----------------------------------------------------------------------
  // per-page register copies
  // ----------------------------------------------------------------------
  wire [1:0] wr_fault, wr_resp, wr_warn, rej, ovf, ovw;
  wire [6:0] fmant [0:1];
  wire [6:0] wmant [0:1];
  wire [2:0] rset  [0:1];
  wire [6:0] imant [0:1];
  assign imant[0] = i0_q;
  assign imant[1] = i1_q;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : page
      wire sel = cmd_wr_in && (page_in == g);
      assign wr_fault[g] = sel && (cmd_code_in == `OCL_CMD_FAULT_THR);
      assign wr_resp[g]  = sel && (cmd_code_in == `OCL_CMD_RETRY_RESP);
      assign wr_warn[g]  = sel && (cmd_code_in == `OCL_CMD_WARN_THR);
      ocl_page_regs u_page (
        .clk_in            (clk_in),
        .sys_rst_in        (sys_rst_in),
        .wr_fault_in       (wr_fault[g]),
        .wr_resp_in        (wr_resp[g]),
        .wr_warn_in        (wr_warn[g]),
        .wr_data_in        (cmd_data_in),
        .iout_mant_in      (imant[g]),
        .fault_mant_out    (fmant[g]),
        .retry_setting_out (rset[g]),
        .warn_mant_out     (wmant[g]),
        .reject_out        (rej[g]),
        .over_fault_out    (ovf[g]),
        .over_warn_out     (ovw[g])
      );
    end
  endgenerate
  // ----------------------------------------------------------------------
  // read-back formatting
  // ----------------------------------------------------------------------
  function [15:0] lin_word;
    input [6:0] mant;
    begin
      lin_word = {`OCL_EXP_NEG_ONE, 4'h0, mant};
    end
  endfunction
  wire [6:0] sel_f = page_in ? fmant[1] : fmant[0];
  wire [6:0] sel_w = page_in ? wmant[1] : wmant[0];
  wire [2:0] sel_r = page_in ? rset[1] : rset[0];
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_data_out <= 16'h0000;
    end else begin
      case (cmd_code_in)
        `OCL_CMD_FAULT_THR:  rd_data_out <= lin_word(sel_f);
        `OCL_CMD_WARN_THR:   rd_data_out <= lin_word(sel_w);
        `OCL_CMD_RETRY_RESP: rd_data_out <= {8'h00, 2'b00, sel_r, 3'b100};
        default:             rd_data_out <= 16'h0000;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // non-volatile store snapshot of both pages
  // ----------------------------------------------------------------------
  wire store_cmd = cmd_wr_in && (cmd_code_in == `OCL_CMD_STORE_ALL);
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      nvm_store_out <= 1'b0;
      nvm_image_out <= 48'h000000000000;
    end else begin
      nvm_store_out <= store_cmd;
      if (store_cmd)
        nvm_image_out <= {1'b0, fmant[1], 2'b00, rset[1], 3'b100, 1'b0, wmant[1],
                          1'b0, fmant[0], 2'b00, rset[0], 3'b100, 1'b0, wmant[0]};
    end
  end
  // ----------------------------------------------------------------------
  // sticky status flags; set wins over clear
  // ----------------------------------------------------------------------
  wire [1:0] fault_ev = ovf | uv_s2;
  wire       cml_ev   = |rej;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      command_fault_flag_out       <= 1'b0;
      invalid_data_flag_out        <= 1'b0;
      overcurrent_summary_flag_out <= 2'b00;
      other_condition_flag_out     <= 2'b00;
      current_power_flag_out       <= 2'b00;
      overcurrent_fault_flag_out   <= 2'b00;
      overcurrent_warning_flag_out <= 2'b00;
    end else begin
      command_fault_flag_out <= cml_ev | (command_fault_flag_out & ~clear_faults_in);
      invalid_data_flag_out  <= cml_ev | (invalid_data_flag_out & ~clear_faults_in);
      overcurrent_summary_flag_out <= fault_ev |
        (overcurrent_summary_flag_out & {2{~clear_faults_in}});
      overcurrent_fault_flag_out <= fault_ev |
        (overcurrent_fault_flag_out & {2{~clear_faults_in}});
      other_condition_flag_out <= ovw |
        (other_condition_flag_out & {2{~clear_faults_in}});
      overcurrent_warning_flag_out <= ovw |
        (overcurrent_warning_flag_out & {2{~clear_faults_in}});
      current_power_flag_out <= fault_ev | ovw |
        (current_power_flag_out & {2{~clear_faults_in}});
    end
  end
  // alert line low while any flag stands
  assign smbalert_n_out = ~(command_fault_flag_out | (|overcurrent_fault_flag_out) |
                            (|overcurrent_warning_flag_out));
  // ----------------------------------------------------------------------
  // per-output fault response sequencer
  // ----------------------------------------------------------------------
  localparam ST_OFF   = 2'd0;
  localparam ST_RUN   = 2'd1;
  localparam ST_LATCH = 2'd2;
  localparam ST_WAIT  = 2'd3;
  reg [1:0]  st  [0:1];
  reg [15:0] cnt [0:1];
  integer    k;
  // one process walks both outputs so every register has a single driver
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (k = 0; k < 2; k = k + 1) begin
        st[k]  <= ST_OFF;
        cnt[k] <= 16'h0000;
      end
      output_enable_out <= 2'b00;
      soft_start_out    <= 2'b00;
    end else begin
      soft_start_out <= 2'b00;
      for (k = 0; k < 2; k = k + 1) begin
        case (st[k])
          ST_OFF: begin
            output_enable_out[k] <= 1'b0;
            if (en_s2[k] && bias_s2 && !oth_s2[k]) begin
              st[k]                <= ST_RUN;
              output_enable_out[k] <= 1'b1;
              soft_start_out[k]    <= 1'b1;
            end
          end
          ST_RUN: begin
            if (!en_s2[k] || !bias_s2 || oth_s2[k]) begin
              st[k]                <= ST_OFF;
              output_enable_out[k] <= 1'b0;
            end else if (fault_ev[k]) begin
              output_enable_out[k] <= 1'b0;
              cnt[k]               <= 16'h0000;
              st[k] <= (rset[k] == `OCL_RS_NO_RESTART) ? ST_LATCH : ST_WAIT;
            end
          end
          ST_LATCH: begin
            output_enable_out[k] <= 1'b0;
            if (clear_faults_in || !en_s2[k])
              st[k] <= ST_OFF;
          end
          ST_WAIT: begin
            output_enable_out[k] <= 1'b0;
            if (!en_s2[k] || !bias_s2 || oth_s2[k])
              st[k] <= ST_OFF;
            else if (cnt[k] == (`OCL_RETRY_CYCLES - 1))
              st[k] <= ST_OFF;
            else
              cnt[k] <= cnt[k] + 16'h0001;
          end
          default: st[k] <= ST_OFF;
        endcase
      end
    end
  end
endmodule // ocl_limit_regs
`default_nettype wire

/* rtl/ocl_page_regs.v */
// one page of overcurrent threshold and retry registers with comparators
`timescale 1ns/1ps
`default_nettype none
`include "ocl_regs.vh"
module ocl_page_regs (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire        wr_fault_in,
  input  wire        wr_resp_in,
  input  wire        wr_warn_in,
  input  wire [15:0] wr_data_in,
  input  wire [6:0]  iout_mant_in,
  output reg  [6:0]  fault_mant_out,
  output reg  [2:0]  retry_setting_out,
  output reg  [6:0]  warn_mant_out,
  output wire        reject_out,
  output wire        over_fault_out,
  output wire        over_warn_out
);
  // ----------------------------------------------------------------------
  // write checks
  // ----------------------------------------------------------------------
  wire [6:0] new_mant = wr_data_in[`OCL_MANT_MSB:0];
  wire [2:0] new_rs   = wr_data_in[`OCL_RS_HI:`OCL_RS_LO];
  wire rs_ok    = (new_rs == `OCL_RS_NO_RESTART) || (new_rs == `OCL_RS_HICCUP);
  wire fault_ok = (new_mant >= warn_mant_out);
  wire warn_ok  = (new_mant <= fault_mant_out);
  assign reject_out = (wr_fault_in && !fault_ok) || (wr_warn_in && !warn_ok) ||
                      (wr_resp_in && !rs_ok);
  // threshold comparison in half-ampere units
  assign over_fault_out = (iout_mant_in > fault_mant_out);
  assign over_warn_out  = (iout_mant_in > warn_mant_out);
  // ----------------------------------------------------------------------
  // storage; rejected writes keep the old value
  // ----------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      fault_mant_out    <= `OCL_FAULT_MANT_RST;
      warn_mant_out     <= `OCL_WARN_MANT_RST;
      retry_setting_out <= `OCL_RS_HICCUP;
    end else begin
      if (wr_fault_in && fault_ok)
        fault_mant_out <= new_mant;
      if (wr_warn_in && warn_ok)
        warn_mant_out <= new_mant;
      if (wr_resp_in && rs_ok)
        retry_setting_out <= new_rs;
    end
  end
endmodule // ocl_page_regs
`default_nettype wire

/* rtl/ocl_regs.vh */
// offsets, field layouts, reset values and timing counts of the overcurrent limit registers
`ifndef OCL_REGS_VH
`define OCL_REGS_VH
// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define OCL_CMD_FAULT_THR    8'h46
`define OCL_CMD_RETRY_RESP   8'h47
`define OCL_CMD_WARN_THR     8'h4A
`define OCL_CMD_STORE_ALL    8'h15
// ----------------------------------------------------------------------
// linear word layout
// ----------------------------------------------------------------------
`define OCL_EXP_NEG_ONE      5'h1F
`define OCL_MANT_MSB         6
`define OCL_FAULT_MANT_RST   7'h3C
`define OCL_WARN_MANT_RST    7'h36
`define OCL_FAULT_MANT_MIN   7'h06
`define OCL_FAULT_MANT_MAX   7'h64
`define OCL_WARN_MANT_MIN    7'h04
`define OCL_WARN_MANT_MAX    7'h62
// ----------------------------------------------------------------------
// retry response layout
// ----------------------------------------------------------------------
`define OCL_RS_HI            5
`define OCL_RS_LO            3
`define OCL_RS_NO_RESTART    3'h0
`define OCL_RS_HICCUP        3'h7
`define OCL_RESP_RST         8'h3C
`define OCL_RESP_RO_MASK     8'hC7
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define OCL_CLK_MHZ          125
`define OCL_RETRY_DELAY_US   20
`define OCL_RETRY_CYCLES     (`OCL_RETRY_DELAY_US * `OCL_CLK_MHZ)
`endif

/* verification/ocl_host_model.sv */
// host side model issuing command writes and reads
`timescale 1ns/1ps
`default_nettype none
module ocl_host_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] rd_data_in,
  output var  logic        page_out,
  output var  logic        cmd_wr_out,
  output var  logic [7:0]  cmd_code_out,
  output var  logic [15:0] cmd_data_out
);
  // idle bus at time zero
  initial begin
    page_out = 1'b0;
    cmd_wr_out = 1'b0;
    cmd_code_out = 8'h00;
    cmd_data_out = 16'h0000;
  end
  // one-cycle strobe, data scrambled once released
  task automatic wr_reg(input logic pg, input logic [7:0] code, input logic [15:0] data);
    @(negedge clk_in);
    page_out = pg;
    cmd_code_out = code;
    cmd_data_out = data;
    cmd_wr_out = 1'b1;
    @(negedge clk_in);
    cmd_wr_out = 1'b0;
    cmd_data_out = ~data;
  endtask
  // present code, take registered answer one edge later
  task automatic rd_reg(input logic pg, input logic [7:0] code, output logic [15:0] data);
    @(negedge clk_in);
    page_out = pg;
    cmd_code_out = code;
    @(negedge clk_in);
    data = rd_data_in;
  endtask
endmodule // ocl_host_model
`default_nettype wire

/* verification/ocl_limit_props.sv */
// assertions on the ports of the overcurrent limit register bank
`timescale 1ns/1ps
`default_nettype none
module ocl_limit_props (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        cmd_wr_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic [15:0] rd_data_out,
  input wire logic        nvm_store_out,
  input wire logic        command_fault_flag_out,
  input wire logic        invalid_data_flag_out,
  input wire logic [1:0]  overcurrent_summary_flag_out,
  input wire logic [1:0]  other_condition_flag_out,
  input wire logic [1:0]  current_power_flag_out,
  input wire logic [1:0]  overcurrent_fault_flag_out,
  input wire logic [1:0]  overcurrent_warning_flag_out,
  input wire logic        smbalert_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // a raised command fault, overcurrent fault or overcurrent warning flag holds the alert line low
  a_alert_on_flags:
    assert property ((command_fault_flag_out || (|overcurrent_fault_flag_out)
      || (|overcurrent_warning_flag_out)) |-> !smbalert_n_out) else $error("alert not low");
  // unsupported retry code raises both command flags next cycle
  a_bad_retry_flags:
    assert property (cmd_wr_in && cmd_code_in == 8'h47 && !(cmd_data_in[5:3] inside {3'h0, 3'h7})
      |=> command_fault_flag_out && invalid_data_flag_out) else $error("bad retry not flagged");
  a_store_pulse:
    assert property (cmd_wr_in && cmd_code_in == 8'h15 |=> nvm_store_out) else $error("no store");
  // fault flag always comes with summary and current flags
  a_fault_flag_group:
    assert property ((overcurrent_fault_flag_out
      & ~(overcurrent_summary_flag_out & current_power_flag_out)) == 2'b00)
      else $error("fault flag group broken");
  a_warn_flag_group:
    assert property ($rose(overcurrent_warning_flag_out[0]) |-> other_condition_flag_out[0]
      && current_power_flag_out[0]) else $error("warning flag group broken");
  // read words keep their fixed fields
  a_fault_word_fixed:
    assert property (cmd_code_in == 8'h46 |=> rd_data_out[15:7] == 9'h1F0)
      else $error("fault word fixed bits wrong");
  a_warn_word_fixed:
    assert property (cmd_code_in == 8'h4A |=> rd_data_out[15:7] == 9'h1F0)
      else $error("warning word fixed bits wrong");
  a_resp_byte_fixed:
    assert property (cmd_code_in == 8'h47 |=> rd_data_out[15:6] == 10'h000
      && rd_data_out[2:0] == 3'h4 && rd_data_out[5:3] inside {3'h0, 3'h7})
      else $error("retry byte wrong");
endmodule // ocl_limit_props
bind ocl_limit_regs ocl_limit_props ocl_limit_props_inst (.*);
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the overcurrent limit register bank
`timescale 1ns/1ps
`default_nettype none
`include "ocl_regs.vh"
module tb;
  localparam logic [15:0] fault_rst = {`OCL_EXP_NEG_ONE, 4'h0, `OCL_FAULT_MANT_RST};
  localparam logic [15:0] warn_rst = {`OCL_EXP_NEG_ONE, 4'h0, `OCL_WARN_MANT_RST};
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        page_in, cmd_wr_in, command_fault_flag_out, invalid_data_flag_out;
  logic        smbalert_n_out, nvm_store_out;
  logic [7:0]  cmd_code_in;
  logic [15:0] cmd_data_in, rd_data_out, exp_resp;
  logic [6:0]  iout0_mant_in = 7'h00;
  logic [6:0]  iout1_mant_in = 7'h00;
  logic [1:0]  uv_fault_in = 2'b00;
  logic [1:0]  enable_cmd_in = 2'b11;
  logic        bias_ok_in = 1'b1;
  logic [1:0]  other_fault_in = 2'b00;
  logic        clear_faults_in = 1'b0;
  logic [1:0]  output_enable_out, soft_start_out, overcurrent_summary_flag_out;
  logic [1:0]  other_condition_flag_out, current_power_flag_out;
  logic [1:0]  overcurrent_fault_flag_out, overcurrent_warning_flag_out;
  logic [47:0] nvm_image_out;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;
  int          ss0 = 0;
  int          ss1 = 0;
  int          n0, n1;
  wire  [8:0]  flags = {overcurrent_warning_flag_out, other_condition_flag_out,
                        current_power_flag_out, overcurrent_fault_flag_out, smbalert_n_out};

  always #4 clk_in = ~clk_in;
  ocl_limit_regs ocl_limit_regs_inst (.*);
  ocl_host_model ocl_host_model_inst (.clk_in(clk_in), .rd_data_in(rd_data_out),
    .page_out(page_in), .cmd_wr_out(cmd_wr_in), .cmd_code_out(cmd_code_in),
    .cmd_data_out(cmd_data_in));

  // count start attempts and cut a hang short, away from the launching edge
  always @(negedge clk_in) begin
    cycles++;
    if (soft_start_out[0] === 1'b1) ss0++;
    if (soft_start_out[1] === 1'b1) ss1++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic pg, input logic [7:0] code, input logic [15:0] data);
    ocl_host_model_inst.wr_reg(pg, code, data);
  endtask
  task automatic rd_chk(input string what, input logic pg, input logic [7:0] code,
                        input logic [15:0] exp);
    logic [15:0] v;
    ocl_host_model_inst.rd_reg(pg, code, v);
    check(what, 48'(v), 48'(exp));
  endtask
  task automatic cml_chk(input string what, input logic bad);
    check(what, 48'({command_fault_flag_out, invalid_data_flag_out, smbalert_n_out}),
          bad ? 48'h6 : 48'h1);
  endtask
  task automatic clr();
    @(negedge clk_in);
    clear_faults_in = 1'b1;
    @(negedge clk_in);
    clear_faults_in = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence of register and current tests
  initial begin
    repeat (16) @(negedge clk_in);
    sys_rst_in = 1'b0;
    idle(3);
    rd_chk("fault0_rst", 1'b0, `OCL_CMD_FAULT_THR, fault_rst);
    rd_chk("warn1_rst", 1'b1, `OCL_CMD_WARN_THR, warn_rst);
    rd_chk("resp1_rst", 1'b1, `OCL_CMD_RETRY_RESP, 16'(`OCL_RESP_RST));
    wr(1'b0, `OCL_CMD_FAULT_THR, 16'hFFE4);
    rd_chk("fault0_wr", 1'b0, `OCL_CMD_FAULT_THR, 16'hF864);
    rd_chk("fault1_kept", 1'b1, `OCL_CMD_FAULT_THR, fault_rst);
    wr(1'b0, `OCL_CMD_WARN_THR, 16'h0065);
    rd_chk("warn_refused", 1'b0, `OCL_CMD_WARN_THR, warn_rst);
    cml_chk("cml_warn", 1'b1);
    clr();
    wr(1'b0, `OCL_CMD_FAULT_THR, 16'h0035);
    rd_chk("fault_refused", 1'b0, `OCL_CMD_FAULT_THR, 16'hF864);
    cml_chk("cml_fault", 1'b1);
    clr();
    exp_resp = 16'h003C;
    for (int rs = 0; rs < 8; rs++) begin
      wr(1'b0, `OCL_CMD_RETRY_RESP, {10'h003, rs[2:0], 3'h7});
      if (rs == 0 || rs == 7) exp_resp = {10'h000, rs[2:0], 3'h4};
      rd_chk("resp_code", 1'b0, `OCL_CMD_RETRY_RESP, exp_resp);
      cml_chk("cml_resp", rs != 0 && rs != 7);
      clr();
    end
    wr(1'b1, `OCL_CMD_RETRY_RESP, 16'h0000);
    iout0_mant_in = 7'd54;
    idle(6);
    check("warn_at_thr", 48'(flags), 48'h001);
    iout0_mant_in = 7'd55;
    idle(6);
    check("warn_flags", 48'(flags), 48'h0A8);
    iout0_mant_in = 7'd101;
    iout1_mant_in = 7'd61;
    idle(6);
    check("fault_flags", 48'({overcurrent_fault_flag_out, overcurrent_summary_flag_out}), 48'hF);
    n0 = ss0;
    n1 = ss1;
    idle(6000);
    check("hiccup", 48'(ss0 - n0 >= 2), 48'h1);
    check("latched", 48'({output_enable_out[1], ss1 != n1}), 48'h0);
    iout0_mant_in = 7'd0;
    iout1_mant_in = 7'd0;
    idle(4);
    clr();
    uv_fault_in = 2'b10;
    idle(6);
    check("uv_fault", 48'({overcurrent_fault_flag_out, overcurrent_summary_flag_out}), 48'hA);
    uv_fault_in = 2'b00;
    wr(1'b0, `OCL_CMD_STORE_ALL, 16'h0000);
    check("store", 48'(nvm_store_out), 48'h1);
    check("image", nvm_image_out, 48'h3C0436643C36);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
